// File: logic/crc_readout_pkg.sv
// Constants, register map and types for the configuration CRC readout block.
// Assumes a single 25 MHz bus clock; every other timing source is emulated on it.
// Function
// - Shift register acts only on readout rising edges
// - Shift mode moves one bit toward output
// - Load mode parallel-loads source picked by select
// - Select zero loads stored pre-computed CRC
// - Select one loads computed signature register
// - Select ignored while shifting
// - Error flag runs in oscillator domain
// - Error high when computed CRC mismatches
// - Pass-done pulses one bus clock cycle per pass
// - Correct operation resumes after memory rewrite
// - Error holds through next pass, clears clean
// - Detection clock is oscillator over two-to-n
// - Configuration end stores pre-computed CRC
package crc_readout_pkg;

    // Register byte offsets within the block's window
    localparam logic [11:0] CTRL_OFF    = 12'h000;  // Enable and clock divider
    localparam logic [11:0] STATUS_OFF  = 12'h004;  // Sticky events, write one to clear
    localparam logic [11:0] MASK_OFF    = 12'h008;  // Interrupt mask, same layout
    localparam logic [11:0] PRECRC_OFF  = 12'h00C;  // Pre-computed CRC from the bitstream
    localparam logic [11:0] SIG_OFF     = 12'h010;  // Last computed signature, read only
    localparam logic [11:0] STATE_OFF   = 12'h014;  // Live state, read only
    localparam logic [11:0] DONE_OFF    = 12'h018;  // Any write ends configuration while the request pin is high
    localparam logic [11:0] STORE_OFF   = 12'h01C;  // Storage register, read only
    localparam logic [3:0]  CFGMEM_PAGE = 4'h1;     // Configuration memory at 0x100 upward

    // Control register fields
    localparam int unsigned CTRL_EN_BIT  = 0;       // Detection enable
    localparam int unsigned CTRL_DIV_LSB = 1;       // Divider exponent n, four bits
    localparam logic [3:0]  DIV_MAX      = 4'h8;    // Largest legal exponent

    // Status, mask and state fields
    localparam int unsigned EV_ERR_BIT   = 0;       // Error flag rose
    localparam int unsigned EV_PASS_BIT  = 1;       // A detection pass completed
    localparam int unsigned ST_ERR_BIT   = 0;       // Current error flag
    localparam int unsigned ST_USER_BIT  = 1;       // Device in user mode
    localparam int unsigned ST_RUN_BIT   = 2;       // Detection running

    // Reset values
    localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
    localparam logic [31:0] MASK_RST     = 32'h0000_0000;
    localparam logic [31:0] PRECRC_RST   = 32'h0000_0000;

    // CRC arithmetic
    localparam logic [31:0] CRC_POLY     = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_INIT     = 32'hFFFF_FFFF;
    localparam int unsigned SHIFT_W      = 32;      // Readout shift register width

    // Synchronised pin indices
    localparam int unsigned PIN_N        = 4;
    localparam int unsigned PIN_RDCLK    = 0;
    localparam int unsigned PIN_SHIFT    = 1;
    localparam int unsigned PIN_LDSRC    = 2;
    localparam int unsigned PIN_RECFG    = 3;

    // Device life cycle
    typedef enum logic {
        MODE_CONFIG,
        MODE_USER
    } mode_t;

endpackage : crc_readout_pkg

// File: logic/config_crc_signature_readout.sv
// Configuration CRC error detection with serial signature readout and AHB-Lite registers.
// Assumes readout clock, select inputs and reconfiguration request arrive asynchronously;
// the internal oscillator is emulated by a tick on hclk, divided by two to the n.
module config_crc_signature_readout #(
    parameter int unsigned CFG_WORDS = 8,           // Emulated configuration memory words
    parameter int unsigned OSC_DIV   = 1            // Bus cycles per oscillator cycle
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        readout_clk,
    input  wire logic        shift_not_load,
    input  wire logic        load_src,
    input  wire logic        reconfig_request_n,
    output logic             crc_error,
    output logic             regout,
    output logic             cycle_complete,
    output logic             irq
);

    localparam int unsigned IDX_W = (CFG_WORDS > 1) ? $clog2(CFG_WORDS) : 1;
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CFG_WORDS - 1);
    localparam int unsigned CNT_W = 16;

    // High when the address falls on a word of the emulated configuration memory
    function automatic logic cfg_hit(input logic [11:0] a);
        return (a[11:8] == crc_readout_pkg::CFGMEM_PAGE) && (32'(a[7:2]) < CFG_WORDS);
    endfunction : cfg_hit

    // One 32-bit word folded into the CRC, most significant bit first
    function automatic logic [31:0] crc_word(input logic [31:0] crc, input logic [31:0] data);
        logic [31:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            if (c[31] ^ data[i]) begin
                c = {c[30:0], 1'b0} ^ crc_readout_pkg::CRC_POLY;
            end else begin
                c = {c[30:0], 1'b0};
            end
        end
        return c;
    endfunction : crc_word

    // Pin synchroniser state
    logic [crc_readout_pkg::PIN_N-1:0] pins;       // Raw asynchronous inputs
    logic [crc_readout_pkg::PIN_N-1:0] s1_q;       // First stage, read only by s2
    logic [crc_readout_pkg::PIN_N-1:0] s2_q;       // Second stage
    logic [crc_readout_pkg::PIN_N-1:0] s3_q;       // Third stage
    logic [crc_readout_pkg::PIN_N-1:0] filt_q;     // Accepted level
    logic [crc_readout_pkg::PIN_N-1:0] filt_d;

    // Bus state
    logic [11:0] addr_q,  addr_d;                  // Captured address of the data phase
    logic        wr_q,    wr_d;                    // Captured direction
    logic        pend_q,  pend_d;                  // Data phase in progress
    logic [31:0] hrdata_q, hrdata_d;
    logic        hready_q, hready_d;
    logic        bus_wr;                           // Write strobe for this cycle
    logic [31:0] rd_val;                           // Read mux result

    // Core state
    logic [31:0] ctrl_q,    ctrl_d;
    logic [31:0] mask_q,    mask_d;
    logic [31:0] precrc_q,  precrc_d;
    logic [1:0]  status_q,  status_d;
    logic [31:0] store_q,   store_d;               // Storage register used by compare
    logic [31:0] sig_q,     sig_d;                 // Signature register
    logic [31:0] acc_q,     acc_d;                 // Running CRC of the current pass
    logic [IDX_W-1:0] widx_q, widx_d;              // Word under check
    logic [CNT_W-1:0] cnt_q, cnt_d;                // Oscillator emulation counter
    logic [31:0] mem_q [CFG_WORDS];                // Emulated configuration memory
    logic [31:0] mem_d [CFG_WORDS];
    logic [crc_readout_pkg::SHIFT_W-1:0] sr_q, sr_d;  // Readout shift register
    crc_readout_pkg::mode_t mode_q, mode_d;
    logic        err_q,  err_d;
    logic        done_q, done_d;
    logic        rgo_q,  rgo_d;
    logic        irq_q,  irq_d;

    assign pins = {reconfig_request_n, load_src, shift_not_load, readout_clk};

    // Three-stage synchroniser; a level is accepted once stages two and three agree
    always_comb begin
        filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Stages start at the pins' idle levels so no false request follows reset
            s1_q   <= 4'h8;
            s2_q   <= 4'h8;
            s3_q   <= 4'h8;
            filt_q <= 4'h8;                        // Request pin idles high
        end else if (ce) begin
            s1_q   <= pins;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    // Register read mux over the captured address
    always_comb begin
        rd_val = 32'h0000_0000;
        case (addr_q)
            crc_readout_pkg::CTRL_OFF:   rd_val = ctrl_q;
            crc_readout_pkg::STATUS_OFF: rd_val = {30'h0, status_q};
            crc_readout_pkg::MASK_OFF:   rd_val = mask_q;
            crc_readout_pkg::PRECRC_OFF: rd_val = precrc_q;
            crc_readout_pkg::SIG_OFF:    rd_val = sig_q;
            crc_readout_pkg::STORE_OFF:  rd_val = store_q;
            crc_readout_pkg::STATE_OFF: begin
                rd_val[crc_readout_pkg::ST_ERR_BIT]  = err_q;
                rd_val[crc_readout_pkg::ST_USER_BIT] = (mode_q == crc_readout_pkg::MODE_USER);
                rd_val[crc_readout_pkg::ST_RUN_BIT]  = (mode_q == crc_readout_pkg::MODE_USER)
                                                       & ctrl_q[crc_readout_pkg::CTRL_EN_BIT];
            end
            default: begin
                // Memory window reads back; anything else reads zero
                if (cfg_hit(addr_q)) begin
                    rd_val = mem_q[addr_q[IDX_W+1:2]];
                end
            end
        endcase
    end

    // Bus slave: one wait state on every transfer so read data leaves a flip-flop
    always_comb begin
        addr_d   = addr_q;
        wr_d     = wr_q;
        pend_d   = 1'b0;
        hrdata_d = hrdata_q;
        hready_d = 1'b1;
        bus_wr   = 1'b0;
        if (pend_q) begin
            // Data phase: hwdata is valid now, complete with ready high
            bus_wr = wr_q;
            if (!wr_q) begin
                hrdata_d = rd_val;
            end
        end else if (hsel && htrans[1] && hready) begin
            // Address phase accepted; sizes other than a word are treated as a word
            addr_d   = {haddr[11:2], 2'b00};
            wr_d     = hwrite;
            pend_d   = 1'b1;
            hready_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q   <= '0;
            wr_q     <= 1'b0;
            pend_q   <= 1'b0;
            hrdata_q <= '0;
            hready_q <= 1'b1;
        end else if (ce) begin
            addr_q   <= addr_d;
            wr_q     <= wr_d;
            pend_q   <= pend_d;
            hrdata_q <= hrdata_d;
            hready_q <= hready_d;
        end
    end

    // Error detection engine, registers and readout shift register
    always_comb begin
        logic [3:0]       divn;
        logic [CNT_W-1:0] lim;
        logic             tick;
        logic             rd_rise;
        logic [31:0]      nxt;
        logic [1:0]       ev;
        divn    = '0;
        lim     = '0;
        tick    = 1'b0;
        rd_rise = 1'b0;
        nxt     = '0;
        ev      = '0;
        ctrl_d   = ctrl_q;
        mask_d   = mask_q;
        precrc_d = precrc_q;
        store_d  = store_q;
        sig_d    = sig_q;
        acc_d    = acc_q;
        widx_d   = widx_q;
        cnt_d    = cnt_q;
        mem_d    = mem_q;
        sr_d     = sr_q;
        mode_d   = mode_q;
        err_d    = err_q;
        done_d   = 1'b0;

        // Divider exponent clamped to the legal range
        divn = ctrl_q[crc_readout_pkg::CTRL_DIV_LSB +: 4];
        if (divn > crc_readout_pkg::DIV_MAX) begin
            divn = crc_readout_pkg::DIV_MAX;
        end
        // Detection clock: oscillator tick every OSC_DIV cycles, then over two to n
        lim  = CNT_W'((OSC_DIV << divn) - 1);
        tick = (cnt_q >= lim);
        cnt_d = tick ? '0 : cnt_q + CNT_W'(1);

        // Register writes
        if (bus_wr) begin
            case (addr_q)
                crc_readout_pkg::CTRL_OFF:   ctrl_d   = hwdata;
                crc_readout_pkg::MASK_OFF:   mask_d   = hwdata;
                crc_readout_pkg::PRECRC_OFF: precrc_d = hwdata;
                crc_readout_pkg::DONE_OFF: begin
                    // End of configuration latches the pre-computed CRC
                    if (filt_q[crc_readout_pkg::PIN_RECFG]) begin
                        store_d = precrc_q;
                        mode_d  = crc_readout_pkg::MODE_USER;
                        acc_d   = crc_readout_pkg::CRC_INIT;
                        widx_d  = '0;
                    end
                end
                default: begin
                    if (cfg_hit(addr_q)) begin
                        mem_d[addr_q[IDX_W+1:2]] = hwdata;
                    end
                end
            endcase
        end

        if (mode_q == crc_readout_pkg::MODE_USER) begin
            if (ctrl_q[crc_readout_pkg::CTRL_EN_BIT] && tick) begin
                // Error flag and pass logic advance only on detection ticks
                nxt = crc_word(acc_q, mem_q[widx_q]);
                if (widx_q == LAST_IDX) begin
                    sig_d  = nxt;
                    // Flag follows each finished pass, so it holds through the next
                    err_d  = (nxt != store_q);
                    done_d = 1'b1;
                    ev[crc_readout_pkg::EV_PASS_BIT] = 1'b1;
                    ev[crc_readout_pkg::EV_ERR_BIT]  = (nxt != store_q) && !err_q;
                    acc_d  = crc_readout_pkg::CRC_INIT;
                    widx_d = '0;
                end else begin
                    acc_d  = nxt;
                    widx_d = widx_q + IDX_W'(1);
                end
            end
        end else begin
            // Configuring: no detection, flag low until a clean restart
            err_d  = 1'b0;
            acc_d  = crc_readout_pkg::CRC_INIT;
            widx_d = '0;
        end

        // Request pin held low forces configuration mode
        if (!filt_q[crc_readout_pkg::PIN_RECFG]) begin
            mode_d = crc_readout_pkg::MODE_CONFIG;
        end

        // Sticky events; a new event wins over a simultaneous clear
        status_d = status_q;
        if (bus_wr && (addr_q == crc_readout_pkg::STATUS_OFF)) begin
            status_d = status_q & ~hwdata[1:0];
        end
        status_d = status_d | ev;
        irq_d    = |(status_d & mask_d[1:0]);

        // Readout register moves only on an accepted readout rising edge
        rd_rise = filt_d[crc_readout_pkg::PIN_RDCLK] & ~filt_q[crc_readout_pkg::PIN_RDCLK];
        if (rd_rise) begin
            if (filt_q[crc_readout_pkg::PIN_SHIFT]) begin
                // Shift toward the serial output; select is not looked at
                sr_d = {1'b0, sr_q[crc_readout_pkg::SHIFT_W-1:1]};
            end else if (filt_q[crc_readout_pkg::PIN_LDSRC]) begin
                sr_d = sig_q;
            end else begin
                sr_d = store_q;
            end
        end
        // Bit zero appears at once after a load; 31 shifts bring out the rest
        rgo_d = sr_d[0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= crc_readout_pkg::CTRL_RST;
            mask_q   <= crc_readout_pkg::MASK_RST;
            precrc_q <= crc_readout_pkg::PRECRC_RST;
            status_q <= '0;
            store_q  <= '0;
            sig_q    <= '0;
            acc_q    <= crc_readout_pkg::CRC_INIT;
            widx_q   <= '0;
            cnt_q    <= '0;
            mem_q    <= '{default: 32'h0000_0000};
            sr_q     <= '0;
            mode_q   <= crc_readout_pkg::MODE_CONFIG;
            err_q    <= 1'b0;
            done_q   <= 1'b0;
            rgo_q    <= 1'b0;
            irq_q    <= 1'b0;
        end else if (ce) begin
            ctrl_q   <= ctrl_d;
            mask_q   <= mask_d;
            precrc_q <= precrc_d;
            status_q <= status_d;
            store_q  <= store_d;
            sig_q    <= sig_d;
            acc_q    <= acc_d;
            widx_q   <= widx_d;
            cnt_q    <= cnt_d;
            mem_q    <= mem_d;
            sr_q     <= sr_d;
            mode_q   <= mode_d;
            err_q    <= err_d;
            done_q   <= done_d;
            rgo_q    <= rgo_d;
            irq_q    <= irq_d;
        end
    end

    // Every output except the tied-off hresp leaves a flip-flop
    assign hrdata         = hrdata_q;
    assign hreadyout      = hready_q;
    assign hresp          = 1'b0;                  // Always OKAY
    assign crc_error      = err_q;
    assign regout         = rgo_q;
    assign cycle_complete = done_q;
    assign irq            = irq_q;

endmodule : config_crc_signature_readout

// File: bench/crc_readout_chk.sv
// Concurrent checks on the readout block's top-level ports.
// Assumes hready is looped back from hreadyout and readout clock phases last six hclk or more.
module crc_readout_chk #(
    parameter int unsigned CFG_WORDS = 8,   // Emulated memory depth
    parameter int unsigned OSC_DIV   = 1    // Bus cycles per oscillator cycle
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        readout_clk,
    input wire logic        shift_not_load,
    input wire logic        load_src,
    input wire logic        reconfig_request_n,
    input wire logic        crc_error,
    input wire logic        regout,
    input wire logic        cycle_complete,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // Single domain, so clock and reset are given once
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A taken address phase stalls exactly one data cycle
    ready_gap_a: assert property (hsel && htrans[1] && hready && ce |=> !hreadyout)
        else $error("hreadyout did not drop after a taken transfer");
    ready_back_a: assert property (!hreadyout && ce |=> hreadyout)
        else $error("hreadyout stayed low a second cycle");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response other than OKAY");
    // A pass covers every memory word, one per tick, so pulses stand apart
    pass_spacing_a: assert property (cycle_complete |=> !cycle_complete [*7])
        else $error("pass-done pulse too long or too close");
    err_rise_a: assert property ($rose(crc_error) |-> cycle_complete)
        else $error("error flag rose outside a pass end");
    // Only a pass end or a reconfiguration may lower the flag
    err_fall_a: assert property (disable iff (!hresetn || !reconfig_request_n)
        $fell(crc_error) |-> cycle_complete)
        else $error("error flag fell inside a pass");
    cfg_clear_a: assert property (!reconfig_request_n [*8] |-> !crc_error)
        else $error("error flag high in configuration mode");
    // Shift register output only moves a synchroniser delay after a readout rise
    readout_edge_a: assert property ($changed(regout) |-> readout_clk && $past(readout_clk, 3))
        else $error("regout moved without a readout rising edge");
endmodule : crc_readout_chk

bind config_crc_signature_readout crc_readout_chk #(
    .CFG_WORDS(CFG_WORDS),
    .OSC_DIV  (OSC_DIV)
) crc_readout_chk_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .readout_clk(readout_clk),
    .shift_not_load(shift_not_load), .load_src(load_src),
    .reconfig_request_n(reconfig_request_n), .crc_error(crc_error), .regout(regout),
    .cycle_complete(cycle_complete), .irq(irq)
);

// File: bench/sig_reader.sv
// Core-logic model that reads the signature serially through the readout pins.
// Assumes hclk is the bus clock; every pin phase lasts six hclk to clear the synchroniser.
module sig_reader (
    input  wire logic hclk,
    input  wire logic regout,
    output logic      readout_clk,
    output logic      shift_not_load,
    output logic      load_src
);
    timeunit 1ns;
    timeprecision 1ps;

    // Readout clock stands low between frames
    initial begin
        readout_clk    = 1'b0;
        shift_not_load = 1'b0;
        load_src       = 1'b0;
    end

    // One load edge then 31 shift edges, LSB first; flip wiggles the ignored select
    task automatic read_sig(input logic src, input logic flip, output logic [31:0] w);
        shift_not_load <= 1'b0;
        load_src       <= src;
        repeat (6) @(posedge hclk);
        for (int i = 0; i < 32; i++) begin
            readout_clk <= 1'b1;
            repeat (6) @(posedge hclk);
            w[i] = regout;
            readout_clk    <= 1'b0;
            shift_not_load <= 1'b1;
            // Toggling here would only matter if the select leaked into shifts
            if (flip) begin
                load_src <= src ^ i[0];
            end
            repeat (6) @(posedge hclk);
        end
        shift_not_load <= 1'b0;
    endtask : read_sig
endmodule : sig_reader

// File: bench/config_crc_signature_readout_test.sv
// Self-checking bench: AHB-Lite register access plus serial signature readout.
// Assumes the design's register map and CRC arithmetic from the shared package.
module config_crc_signature_readout_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WORDS = 8;          // Small memory keeps passes short
    logic        hclk = 1'b0;
    logic        hresetn, ce, hsel, hwrite, reconfig_request_n;
    logic [31:0] haddr, hwdata, hrdata, rd, good_crc, bad_crc;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, readout_clk, shift_not_load, load_src;
    logic        crc_error, regout, cycle_complete, irq;
    logic [31:0] mem [WORDS];                   // Bench copy of configuration memory
    int          failures = 0;
    int          samples_checked = 0;
    int          span;
    int          exps [4] = '{0, 3, 8, 12};

    // 25 MHz bus clock
    always #20 hclk = ~hclk;

    config_crc_signature_readout #(.CFG_WORDS(WORDS), .OSC_DIV(1)) config_crc_signature_readout_i (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .readout_clk(readout_clk), .shift_not_load(shift_not_load), .load_src(load_src),
        .reconfig_request_n(reconfig_request_n), .crc_error(crc_error), .regout(regout),
        .cycle_complete(cycle_complete), .irq(irq));
    sig_reader sig_reader_i (.hclk(hclk), .regout(regout), .readout_clk(readout_clk),
        .shift_not_load(shift_not_load), .load_src(load_src));

    // MSB-first CRC over the bench memory copy
    function automatic logic [31:0] crc_of();
        logic [31:0] c;
        c = 32'hFFFF_FFFF;
        for (int i = 0; i < WORDS; i++) begin
            for (int b = 31; b >= 0; b--) begin
                c = (c[31] ^ mem[i][b]) ? ((c << 1) ^ 32'h04C1_1DB7) : (c << 1);
            end
        end
        return c;
    endfunction : crc_of

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // Single word transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rdchk

    // Bounded wait for one pass-done pulse
    task automatic wait_pass();
        span = 0;
        do begin
            @(posedge hclk);
            span++;
        end while (cycle_complete !== 1'b1 && span < 5000);
        if (cycle_complete !== 1'b1) failures++;    // Limit ran out
    endtask : wait_pass

    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge hclk);
        failures++;
        wrap_up();
    end

    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        ce                 = 1'b1;
        reconfig_request_n = 1'b1;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("ctrl reset", crc_readout_pkg::CTRL_OFF, crc_readout_pkg::CTRL_RST);
        rdchk("mask reset", crc_readout_pkg::MASK_OFF, crc_readout_pkg::MASK_RST);
        rdchk("unmapped", 12'h0F0, 32'h0000_0000);
        for (int i = 0; i < WORDS; i++) begin
            mem[i] = {16'hA5A5, 8'(i), 8'hC3};
            xfer(1'b1, {crc_readout_pkg::CFGMEM_PAGE, 8'(i * 4)}, mem[i]);
        end
        good_crc = crc_of();
        xfer(1'b1, crc_readout_pkg::PRECRC_OFF, good_crc);
        xfer(1'b1, crc_readout_pkg::DONE_OFF, 32'h0000_0000);
        rdchk("storage", crc_readout_pkg::STORE_OFF, good_crc);
        xfer(1'b1, crc_readout_pkg::MASK_OFF, 32'h0000_0001);
        wait_pass();
        wait_pass();
        rdchk("signature", crc_readout_pkg::SIG_OFF, good_crc);
        chk("clean error", 32'h0, {31'h0, crc_error});
        sig_reader_i.read_sig(1'b0, 1'b0, rd);
        chk("readout stored", good_crc, rd);
        // Upset one configuration bit
        mem[3][0] = ~mem[3][0];
        xfer(1'b1, {crc_readout_pkg::CFGMEM_PAGE, 8'h0C}, mem[3]);
        bad_crc = crc_of();
        wait_pass();
        wait_pass();
        @(posedge hclk);
        chk("error set", 32'h1, {31'h0, crc_error});
        chk("irq error", 32'h1, {31'h0, irq});
        rdchk("signature bad", crc_readout_pkg::SIG_OFF, bad_crc);
        sig_reader_i.read_sig(1'b1, 1'b1, rd);
        chk("readout computed", bad_crc, rd);
        sig_reader_i.read_sig(1'b0, 1'b1, rd);
        chk("readout stored again", good_crc, rd);
        wait_pass();
        @(posedge hclk);
        chk("error holds", 32'h1, {31'h0, crc_error});
        rdchk("status both", crc_readout_pkg::STATUS_OFF, 32'h0000_0003);
        xfer(1'b1, crc_readout_pkg::STATUS_OFF, 32'h0000_0001);
        xfer(1'b0, crc_readout_pkg::STATUS_OFF, 32'h0000_0000);
        chk("status cleared", 32'h0, {31'h0, rd[0]});
        @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        xfer(1'b1, crc_readout_pkg::MASK_OFF, 32'h0000_0002);
        wait_pass();
        repeat (2) @(posedge hclk);
        chk("irq pass", 32'h1, {31'h0, irq});
        xfer(1'b1, crc_readout_pkg::MASK_OFF, 32'h0000_0000);
        @(posedge hclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        // Reconfiguration request, then rewrite the upset bit
        reconfig_request_n <= 1'b0;
        repeat (10) @(posedge hclk);
        chk("error in config", 32'h0, {31'h0, crc_error});
        reconfig_request_n <= 1'b1;
        repeat (6) @(posedge hclk);
        mem[3][0] = ~mem[3][0];
        xfer(1'b1, {crc_readout_pkg::CFGMEM_PAGE, 8'h0C}, mem[3]);
        xfer(1'b1, crc_readout_pkg::DONE_OFF, 32'h0000_0000);
        wait_pass();
        wait_pass();
        @(posedge hclk);
        chk("error after repair", 32'h0, {31'h0, crc_error});
        rdchk("signature repaired", crc_readout_pkg::SIG_OFF, good_crc);
        rdchk("state running", crc_readout_pkg::STATE_OFF, 32'h0000_0006);
        // Divider exponents, the last one beyond the legal range
        foreach (exps[k]) begin
            xfer(1'b1, crc_readout_pkg::CTRL_OFF, 32'(1 + 2 * exps[k]));
            wait_pass();
            wait_pass();
            wait_pass();
            chk("pass period", 32'(WORDS << (exps[k] > 8 ? 8 : exps[k])), 32'(span));
        end
        wrap_up();
    end
endmodule : config_crc_signature_readout_test
